// *** verilog/blp_ctrl.sv ***
// Break entry, flag protection, wait/stop sequencing and status registers
// Summary of operation
// - Break request outside stop and recovery forces the processor to the software-interrupt vector.
// - In break with clear enable low, other modules' flag clears are blocked.
// - A flag cleared in break with clearing enabled stays cleared afterwards.
// - Two-step clears stay blocked in break with clear enable low; second step after break clears.
// - Wait or stop clears the interrupt mask and stops processor clocks.
// - Wait gates processor clocks while peripheral clocks keep running.
// - Enabled interrupt wakes wait; stacking starts one cycle later.
// - Reset or break also ends wait; break sets break-exited-wait flag.
// - Watchdog disable option zero keeps watchdog running during wait.
// - Stop resets recovery counter and disables base and crystal clocks.
// - Stop ends on interrupt or reset; stacking waits for recovery.
// - Recovery is 4096 crystal cycles normally, 32 with short option.
// - Break module is inactive in stop; its registers are unchanged.
// - Recovery counter held reset in stop, then times recovery.
// - Three registers decoded: break status, reset cause, flag control.
// - Break-exited-wait flag reads one, cleared by writing zero or reset.
// - Reading reset cause clears it; power-on sets only its own flag.
// - Reset cause holds power-on, pin, watchdog, opcode, address, voltage.
// - Flag clear enable is read/write and gates clears during break.
// - Recovery counter is 13 bits, on the crystal clock falling edge.
`timescale 1ns/1ps
`default_nettype none
module blp_ctrl (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst_b,
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [17:0]           i_paddr,
   input  wire logic [31:0]           i_pwdata,
   output logic                       o_pready,
   output logic [31:0]                o_prdata,
   output logic                       o_pslverr,
   input  wire logic                  i_break_req,
   input  wire logic                  i_wait_instr,
   input  wire logic                  i_stop_instr,
   input  wire logic                  i_irq_pending,
   input  wire logic                  i_xtal_fall,
   input  wire logic                  i_short_stop_recovery_select,
   input  wire logic                  i_watchdog_disable_option,
   input  wire blp_pkg::blp_rst_src_s i_rst_src,
   input  wire logic                  i_flag_clear_req,
   input  wire logic                  i_two_step_second,
   output logic                       o_force_swi_vector,
   output logic                       o_clear_imask,
   output logic                       o_stack_start,
   output blp_pkg::blp_clk_s          o_clk_en,
   output logic                       o_watchdog_run,
   output logic                       o_break_module_en,
   output logic                       o_flag_clear_allow,
   output logic                       o_in_break
);
   import blp_pkg::*;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire logic acc      = i_psel & i_penable;
   wire logic hit_bs   = i_paddr == BLP_ADDR_BREAK_STATUS;
   wire logic hit_rc   = i_paddr == BLP_ADDR_RESET_CAUSE;
   wire logic hit_fc   = i_paddr == BLP_ADDR_BREAK_FLAG_CTRL;
   wire logic hit_any  = hit_bs | hit_rc | hit_fc;
   // Writes and read-clear land on the edge that completes the access
   wire logic wr_bs    = acc & i_pwrite & hit_bs & o_pready;
   wire logic wr_fc    = acc & i_pwrite & hit_fc & o_pready;
   wire logic rd_rc    = acc & ~i_pwrite & hit_rc & o_pready;

   // ****************************************************************
   // State
   // ****************************************************************
   blp_state_e     state_r, state_nxt;
   logic [12:0]    rec_cnt_r, rec_cnt_nxt;
   logic           bw_r, flag_clear_in_break_enable_r, in_break_r;
   logic [7:0]     rc_r, rc_nxt;
   logic           rc_loaded_r;

   wire logic [12:0] rec_target = i_short_stop_recovery_select ?
                                  BLP_REC_SHORT : BLP_REC_LONG;
   wire logic rec_done = rec_cnt_r == rec_target - 13'h0001;
   wire logic wait_break = (state_r == BLP_WAIT) & i_break_req;
   wire logic wait_wake  = (state_r == BLP_WAIT) & i_irq_pending;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BLP_RUN: begin
            if (i_stop_instr) begin
               state_nxt = BLP_STOP;
            end else if (i_wait_instr) begin
               state_nxt = BLP_WAIT;
            end
         end
         BLP_WAIT: begin
            if (i_irq_pending | i_break_req) begin
               state_nxt = BLP_RUN;
            end
         end
         BLP_STOP: begin
            if (i_irq_pending) begin
               state_nxt = BLP_REC;
            end
         end
         BLP_REC: begin
            if (i_xtal_fall & rec_done) begin
               state_nxt = BLP_RUN;
            end
         end
         default: state_nxt = BLP_RUN;
      endcase
   end

   // Counter is held clear in stop and counts crystal falling edges after
   always_comb begin
      rec_cnt_nxt = rec_cnt_r;
      if (state_r != BLP_REC) begin
         rec_cnt_nxt = 13'h0000;
      end else if (i_xtal_fall) begin
         rec_cnt_nxt = rec_cnt_r + 13'h0001;
      end
   end

   // Reset cause: loaded once after release, cleared on read
   always_comb begin
      rc_nxt = rc_r;
      if (!rc_loaded_r) begin
         rc_nxt = 8'h00;
         if (i_rst_src.por) begin
            rc_nxt[BLP_BIT_POR] = 1'b1;
         end else begin
            rc_nxt[BLP_BIT_PIN]  = i_rst_src.pin;
            rc_nxt[BLP_BIT_WDOG] = i_rst_src.wdog;
            rc_nxt[BLP_BIT_ILLEGAL_OPCODE_FLAG] = i_rst_src.illegal_opcode_flag;
            rc_nxt[BLP_BIT_ILLEGAL_ADDRESS_FLAG] = i_rst_src.illegal_address_flag;
            rc_nxt[BLP_BIT_LVR]  = i_rst_src.lvr;
         end
      end else if (rd_rc) begin
         rc_nxt = 8'h00;
      end
   end

   wire logic [7:0] rd_mux = hit_bs ? {6'h00, bw_r, 1'b0} :
                             hit_rc ? rc_r :
                             hit_fc ? {flag_clear_in_break_enable_r, 7'h00} : 8'h00;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r     <= BLP_RUN;
         rec_cnt_r   <= 13'h0000;
         rc_r        <= BLP_RST_VAL;
         rc_loaded_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         rec_cnt_r   <= rec_cnt_nxt;
         rc_r        <= rc_nxt;
         rc_loaded_r <= 1'b1;
      end
   end

   // ****************************************************************
   // Break status, flag control and break tracking
   // ****************************************************************
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bw_r            <= 1'b0;
         flag_clear_in_break_enable_r          <= 1'b0;
         in_break_r      <= 1'b0;
      end else begin
         // Set wins over a software clear in the same cycle
         if (wait_break) begin
            bw_r <= 1'b1;
         end else if (wr_bs & ~i_pwdata[BLP_BIT_BW]) begin
            bw_r <= 1'b0;
         end
         if (wr_fc) begin
            flag_clear_in_break_enable_r <= i_pwdata[BLP_BIT_FLAG_CLEAR_IN_BREAK_ENABLE];
         end
         if (i_break_req & (state_r != BLP_STOP) & (state_r != BLP_REC)) begin
            in_break_r <= 1'b1;
         end else if (i_irq_pending & ~i_break_req) begin
            in_break_r <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   wire logic clear_ok = ~in_break_r | flag_clear_in_break_enable_r;
   wire logic low_pwr_entry = (state_r == BLP_RUN) &
                              (i_wait_instr | i_stop_instr);

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pready           <= 1'b0;
         o_prdata           <= 32'h0000_0000;
         o_pslverr          <= 1'b0;
         o_force_swi_vector <= 1'b0;
         o_clear_imask      <= 1'b0;
         o_stack_start      <= 1'b0;
         o_clk_en           <= '{1'b1, 1'b1, 1'b1, 1'b1};
         o_watchdog_run     <= 1'b0;
         o_break_module_en  <= 1'b1;
         o_flag_clear_allow <= 1'b1;
         o_in_break         <= 1'b0;
      end else begin
         o_pready  <= acc & ~o_pready;
         o_prdata  <= (acc & ~i_pwrite & ~o_pready) ?
                      {24'h00_0000, rd_mux} : 32'h0000_0000;
         o_pslverr <= acc & ~o_pready & ~hit_any;
         o_force_swi_vector <= i_break_req & (state_r != BLP_STOP)
                               & (state_r != BLP_REC);
         o_clear_imask      <= low_pwr_entry;
         o_stack_start      <= wait_wake | ((state_r == BLP_REC)
                               & i_xtal_fall & rec_done);
         o_clk_en.cpu_clk_en  <= state_nxt == BLP_RUN;
         o_clk_en.per_clk_en  <= (state_nxt == BLP_RUN)
                                 | (state_nxt == BLP_WAIT);
         o_clk_en.base_clk_en <= state_nxt != BLP_STOP;
         o_clk_en.xtal_clk_en <= state_nxt != BLP_STOP;
         o_watchdog_run     <= ~i_watchdog_disable_option
                               & (state_nxt != BLP_STOP);
         o_break_module_en  <= (state_nxt != BLP_STOP)
                               & (state_nxt != BLP_REC);
         // Second step of a two-step clear stays blocked in break while clear enable is low
         o_flag_clear_allow <= clear_ok
                               & ~(in_break_r & i_two_step_second
                               & ~flag_clear_in_break_enable_r);
         o_in_break         <= in_break_r;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   // Clock enables are registered from the next state, so they track state_r
   a_wait_cpu_gated: assert property ((state_r == BLP_WAIT)
      |-> !o_clk_en.cpu_clk_en && o_clk_en.per_clk_en)
      else $error("cpu clock not gated in wait");
   a_stop_clk_off: assert property ((state_r == BLP_STOP)
      |-> !o_clk_en.base_clk_en && !o_clk_en.xtal_clk_en)
      else $error("clocks running in stop");
   a_bw_set_break: assert property (wait_break |=> bw_r)
      else $error("break exit from wait did not set flag");
   a_bw_clear_wr: assert property (wr_bs && !i_pwdata[BLP_BIT_BW]
      && !wait_break |=> !bw_r)
      else $error("flag not cleared by write of zero");
   a_rc_read_clear: assert property (rd_rc && rc_loaded_r
      |=> rc_r == 8'h00)
      else $error("reset cause not cleared by read");
   a_flag_protect: assert property (in_break_r && !flag_clear_in_break_enable_r
      |=> !o_flag_clear_allow)
      else $error("flag clear allowed during protected break");
   a_imask_clear: assert property (low_pwr_entry |=> o_clear_imask)
      else $error("interrupt mask not cleared");
   a_wait_stack: assert property (wait_wake |=> o_stack_start)
      else $error("stacking not one cycle after wake");
   a_rec_held: assert property ((state_r == BLP_STOP)
      |-> rec_cnt_r == 13'h0000)
      else $error("recovery counter not held in stop");
   a_swi_force: assert property (i_break_req && state_r == BLP_RUN
      |=> o_force_swi_vector)
      else $error("break did not force vector");
   a_wdog_wait: assert property (state_r == BLP_WAIT
      && !i_watchdog_disable_option |=> o_watchdog_run)
      else $error("watchdog stopped in wait");

   // ****************************************************************
   // Low-power sequencing checks
   // ****************************************************************
   a_wait_entry: assert property (state_r == BLP_RUN && i_wait_instr
      && !i_stop_instr |=> state_r == BLP_WAIT)
      else $error("wait instruction not taken");
   a_stop_entry: assert property (state_r == BLP_RUN && i_stop_instr
      |=> state_r == BLP_STOP)
      else $error("stop instruction not taken");
   a_stop_hold: assert property (state_r == BLP_STOP && !i_irq_pending
      |=> state_r == BLP_STOP)
      else $error("stop left without interrupt");
   a_stop_wake: assert property (state_r == BLP_STOP && i_irq_pending
      |=> state_r == BLP_REC)
      else $error("interrupt did not start recovery");
   a_rec_count: assert property (state_r == BLP_REC && i_xtal_fall
      && !rec_done |=> rec_cnt_r == $past(rec_cnt_r) + 13'h0001)
      else $error("recovery counter did not advance");
   a_rec_stack: assert property (state_r == BLP_REC && i_xtal_fall
      && rec_done |=> o_stack_start && o_clk_en.cpu_clk_en)
      else $error("stacking not started after recovery");
   a_rec_cpu_off: assert property (state_r == BLP_REC
      |-> !o_clk_en.cpu_clk_en)
      else $error("cpu clocked during recovery");
   a_brk_mod_stop: assert property (state_r == BLP_STOP
      |-> !o_break_module_en)
      else $error("break module active in stop");
   a_wait_brk_exit: assert property (wait_break
      |=> state_r == BLP_RUN)
      else $error("break did not end wait");
   a_wdog_disable: assert property (i_watchdog_disable_option
      |=> !o_watchdog_run)
      else $error("watchdog runs while disabled");
   // ****************************************************************
   // Break protection and register checks
   // ****************************************************************
   a_break_enter: assert property (i_break_req && state_r == BLP_WAIT
      |=> in_break_r)
      else $error("break state not entered");
   a_clear_enabled: assert property (flag_clear_in_break_enable_r
      |=> o_flag_clear_allow)
      else $error("clear blocked with enable set");
   a_two_step_blk: assert property (in_break_r && i_two_step_second
      && !flag_clear_in_break_enable_r |=> !o_flag_clear_allow)
      else $error("second clear step not blocked");
   a_after_break: assert property (!in_break_r
      |=> o_flag_clear_allow)
      else $error("clear blocked outside break");
   a_rc_por_only: assert property (!rc_loaded_r && i_rst_src.por
      |=> rc_r == (8'h01 << BLP_BIT_POR))
      else $error("power-on cause not alone");
   a_rc_wr_ignored: assert property (acc && i_pwrite && hit_rc
      && rc_loaded_r |=> rc_r == $past(rc_r))
      else $error("reset cause changed by write");
   a_flag_clear_in_break_enable_write: assert property (wr_fc
      |=> flag_clear_in_break_enable_r == $past(i_pwdata[BLP_BIT_FLAG_CLEAR_IN_BREAK_ENABLE]))
      else $error("clear enable not written");
   a_err_unmapped: assert property (acc && !o_pready && !hit_any
      |=> o_pslverr)
      else $error("unmapped access without error");
   a_upper_zero: assert property (o_pready
      |-> o_prdata[31:8] == 24'h00_0000)
      else $error("unused read bits not zero");
   a_pready_pulse: assert property (o_pready
      |=> !o_pready)
      else $error("ready longer than one cycle");

   c_stop_entry: cover property (state_r == BLP_RUN && i_stop_instr);
   c_wait_wake: cover property (wait_wake);
   c_wait_break: cover property (wait_break);
   c_stop_rec: cover property (state_r == BLP_REC ##1 state_r == BLP_RUN);
   c_rc_read: cover property (rd_rc);
endmodule : blp_ctrl
`default_nettype wire

// *** verilog/blp_pkg.sv ***
// Package for the break, low-power and reset-cause control block
package blp_pkg;
   // ****************************************************************
   // Register map (printed offsets are not all multiples of four,
   // so they are register indices; byte address is four times)
   // ****************************************************************
   localparam logic [15:0] BLP_IDX_BREAK_STATUS    = 16'hfe00;
   localparam logic [15:0] BLP_IDX_RESET_CAUSE     = 16'hfe01;
   localparam logic [15:0] BLP_IDX_BREAK_FLAG_CTRL = 16'hfe03;
   localparam logic [17:0] BLP_ADDR_BREAK_STATUS    = {BLP_IDX_BREAK_STATUS, 2'b00};
   localparam logic [17:0] BLP_ADDR_RESET_CAUSE     = {BLP_IDX_RESET_CAUSE, 2'b00};
   localparam logic [17:0] BLP_ADDR_BREAK_FLAG_CTRL = {BLP_IDX_BREAK_FLAG_CTRL, 2'b00};
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int BLP_BIT_BW   = 1;
   localparam int BLP_BIT_FLAG_CLEAR_IN_BREAK_ENABLE = 7;
   localparam int BLP_BIT_POR  = 7;
   localparam int BLP_BIT_PIN  = 6;
   localparam int BLP_BIT_WDOG = 5;
   localparam int BLP_BIT_ILLEGAL_OPCODE_FLAG = 4;
   localparam int BLP_BIT_ILLEGAL_ADDRESS_FLAG = 3;
   localparam int BLP_BIT_LVR  = 1;
   localparam logic [7:0] BLP_RST_VAL = 8'h00;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int          BLP_CNT_W      = 13;
   localparam logic [12:0] BLP_REC_LONG   = 13'h1000;
   localparam logic [12:0] BLP_REC_SHORT  = 13'h0020;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      BLP_RUN  = 2'b00,
      BLP_WAIT = 2'b01,
      BLP_STOP = 2'b10,
      BLP_REC  = 2'b11
   } blp_state_e;
   typedef struct packed {
      logic por;
      logic pin;
      logic wdog;
      logic illegal_opcode_flag;
      logic illegal_address_flag;
      logic lvr;
   } blp_rst_src_s;
   typedef struct packed {
      logic cpu_clk_en;
      logic per_clk_en;
      logic base_clk_en;
      logic xtal_clk_en;
   } blp_clk_s;
endpackage : blp_pkg

// *** verif/blp_core_model.sv ***
// Far-side model: crystal oscillator falling-edge pulses
`timescale 1ns/1ps
`default_nettype none
module blp_core_model #(
   parameter int XTAL_DIV = 3
) (
   input  wire logic i_sys_clk,
   input  wire logic i_rst_b,
   output logic      o_xtal_fall
);
   // ****************************************************************
   // Oscillator runs on; stop only gates its use downstream
   // ****************************************************************
   int unsigned div_r;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_r       <= 0;
         o_xtal_fall <= 1'b0;
      end else begin
         div_r       <= (div_r == XTAL_DIV - 1) ? 0 : div_r + 1;
         o_xtal_fall <= (div_r == 0);
      end
   end
endmodule : blp_core_model
`default_nettype wire

// *** verif/break_lowpower_status_control_test.sv ***
// Testbench for the break, low-power and reset-cause control block
`timescale 1ns/1ps
`default_nettype none
module break_lowpower_status_control_test;
   import blp_pkg::*;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic         clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [17:0]  paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic         brk, wait_i, stop_i, irq, xtal, short_stop_recovery_select, wdis, two, er;
   logic         software_interrupt_instr, imask, stack, wdog_run, brk_en, allow, in_brk;
   blp_rst_src_s rst_src;
   blp_clk_s     clk_en;
   int           err_total, n_checks, n;
   wire logic [3:0] mon = {stack, imask, software_interrupt_instr, xtal};
   localparam int M_STACK = 3, M_IMASK = 2, M_SWI = 1;
   blp_ctrl blp_ctrl_inst (.i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .i_break_req(brk), .i_wait_instr(wait_i),
      .i_stop_instr(stop_i), .i_irq_pending(irq), .i_xtal_fall(xtal),
      .i_short_stop_recovery_select(short_stop_recovery_select),
      .i_watchdog_disable_option(wdis), .i_rst_src(rst_src),
      .i_flag_clear_req(1'b0), .i_two_step_second(two),
      .o_force_swi_vector(software_interrupt_instr), .o_clear_imask(imask),
      .o_stack_start(stack), .o_clk_en(clk_en), .o_watchdog_run(wdog_run),
      .o_break_module_en(brk_en), .o_flag_clear_allow(allow),
      .o_in_break(in_brk));
   blp_core_model blp_core_model_inst (.i_sys_clk(clk), .i_rst_b(rst_b),
      .o_xtal_fall(xtal));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wait_bit(input int b, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
      end while (mon[b] !== 1'b1 && cnt < lim);
      if (mon[b] !== 1'b1) begin
         $display("FAIL wait on monitor bit %0d expected 1 seen 0", b);
         err_total++;
         print_verdict();
      end
   endtask : wait_bit
   task apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
      int k;
      @(posedge clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         $display("FAIL pready expected 1 seen 0");
         err_total++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task instr(input logic stp);
      @(posedge clk);
      if (stp) stop_i <= 1'b1;
      else wait_i <= 1'b1;
      @(posedge clk);
      stop_i <= 1'b0; wait_i <= 1'b0;
      wait_bit(M_IMASK, 4, n);
   endtask : instr
   task reset_dut(input blp_rst_src_s src);
      @(posedge clk);
      rst_b <= 1'b0; rst_src <= src;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : reset_dut
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task sc_regs_after_por();
      apb(1'b0, BLP_ADDR_RESET_CAUSE, 32'h0000_0000);
      chk("por cause", rd, 32'(1) << BLP_BIT_POR);
      apb(1'b0, BLP_ADDR_RESET_CAUSE, 32'h0000_0000);
      chk("cause cleared", rd, 32'h0000_0000);
      apb(1'b0, BLP_ADDR_BREAK_STATUS + 18'h0_0008, 32'h0000_0000);
      chk("unmapped err", 32'(er), 32'h0000_0001);
      chk("unmapped data", rd, 32'h0000_0000);
   endtask : sc_regs_after_por
   task sc_wait_irq();
      instr(1'b0);
      @(negedge clk);
      chk("wait clocks", 32'(clk_en), 32'h0000_0007);
      chk("watchdog run", 32'(wdog_run), 32'h0000_0001);
      @(posedge clk);
      irq <= 1'b1;
      wait_bit(M_STACK, 6, n);
      chk("wake delay", 32'(n), 32'h0000_0002);
      chk("woken clocks", 32'(clk_en), 32'h0000_000f);
      @(posedge clk);
      irq <= 1'b0;
   endtask : sc_wait_irq
   task sc_break_in_wait();
      apb(1'b1, BLP_ADDR_BREAK_FLAG_CTRL, 32'h0000_0000);
      instr(1'b0);
      @(posedge clk);
      brk <= 1'b1; two <= 1'b1;
      wait_bit(M_SWI, 4, n);
      @(negedge clk);
      chk("in break", 32'(in_brk), 32'h0000_0001);
      chk("protected", 32'(allow), 32'h0000_0000);
      @(posedge clk);
      brk <= 1'b0;
      apb(1'b0, BLP_ADDR_BREAK_STATUS, 32'h0000_0000);
      chk("break wait flag", rd, 32'(1) << BLP_BIT_BW);
      apb(1'b1, BLP_ADDR_BREAK_FLAG_CTRL, 32'hffff_ffff);
      apb(1'b0, BLP_ADDR_BREAK_FLAG_CTRL, 32'h0000_0000);
      chk("clear enable", rd, 32'(1) << BLP_BIT_FLAG_CLEAR_IN_BREAK_ENABLE);
      chk("clear allowed", 32'(allow), 32'h0000_0001);
      apb(1'b1, BLP_ADDR_BREAK_STATUS, 32'h0000_0000);
      apb(1'b0, BLP_ADDR_BREAK_STATUS, 32'h0000_0000);
      chk("flag write zero", rd, 32'h0000_0000);
      apb(1'b1, BLP_ADDR_BREAK_FLAG_CTRL, 32'h0000_0000);
      @(posedge clk);
      irq <= 1'b1;
      repeat (3) @(posedge clk);
      irq <= 1'b0;
      @(negedge clk);
      chk("break left", 32'(in_brk), 32'h0000_0000);
      chk("second step", 32'(allow), 32'h0000_0001);
      @(posedge clk);
      two <= 1'b0;
   endtask : sc_break_in_wait
   task sc_stop(input logic s);
      int cnt, k, lim;
      int exp;
      exp = s ? int'(BLP_REC_SHORT) : int'(BLP_REC_LONG);
      lim = exp * 3 + 40;
      @(posedge clk);
      short_stop_recovery_select <= s;
      instr(1'b1);
      @(negedge clk);
      chk("stop clocks", 32'(clk_en), 32'h0000_0000);
      chk("break idle", 32'(brk_en), 32'h0000_0000);
      @(posedge clk);
      irq <= 1'b1;
      cnt = 0;
      k = 0;
      do begin
         @(negedge clk);
         if (xtal === 1'b1) cnt++;
         k++;
      end while (stack !== 1'b1 && k < lim);
      chk("recovery", 32'(cnt >= exp && cnt <= exp + 1), 1);
      chk("run clocks", 32'(clk_en), 32'h0000_000f);
      chk("break back", 32'(brk_en), 32'h0000_0001);
      @(posedge clk);
      irq <= 1'b0;
      if (stack !== 1'b1) print_verdict();
   endtask : sc_stop
   task sc_reset_causes();
      int pos [5];
      pos = '{BLP_BIT_LVR, BLP_BIT_ILLEGAL_ADDRESS_FLAG, BLP_BIT_ILLEGAL_OPCODE_FLAG, BLP_BIT_WDOG, BLP_BIT_PIN};
      for (int i = 0; i < 5; i++) begin
         reset_dut(blp_rst_src_s'(6'(1 << i)));
         apb(1'b0, BLP_ADDR_RESET_CAUSE, 32'h0000_0000);
         chk("reset source", rd, 32'(1) << pos[i]);
         apb(1'b0, BLP_ADDR_BREAK_STATUS, 32'h0000_0000);
         chk("flag after reset", rd, 32'h0000_0000);
      end
   endtask : sc_reset_causes
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      err_total = 0; n_checks = 0;
      rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 18'h0_0000; pwdata = 32'h0000_0000; brk = 1'b0;
      wait_i = 1'b0; stop_i = 1'b0; irq = 1'b0; short_stop_recovery_select = 1'b0;
      wdis = 1'b0; two = 1'b0; rst_src = blp_rst_src_s'(6'h3f);
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      sc_regs_after_por();
      sc_wait_irq();
      sc_break_in_wait();
      sc_stop(1'b1);
      sc_stop(1'b0);
      sc_reset_causes();
      print_verdict();
   end
endmodule : break_lowpower_status_control_test
`default_nettype wire
